// [logic/bbx_pkg.sv]
`default_nettype none
package bbx_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int PC_W = 12;
    localparam int DS_AW = 8;
    localparam int DATA_W = 8;
    localparam int STACK_DEPTH = 6;
    localparam int SP_W = 3;
    localparam logic [PC_W-1:0] RESET_PC = 12'h000;
    localparam logic [SP_W-1:0] STACK_LAST = 3'h5;

    // ------------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------------
    localparam int COND_LSB = 0;
    localparam int REL_DISP_LSB = 3;
    localparam int BIT_POLARITY_POS = 4;
    localparam int ADDR_HI_LSB = 4;
    localparam logic [2:0] COND_NZ = 3'h0;
    localparam logic [2:0] COND_NC = 3'h2;
    localparam logic [2:0] COND_Z = 3'h4;
    localparam logic [2:0] COND_C = 3'h6;
    localparam logic [3:0] COL_CALL = 4'h1;
    localparam logic [3:0] COL_BTEST = 4'h3;
    localparam logic [3:0] COL_JUMP = 4'h9;
    localparam logic [3:0] COL_BMOD = 4'hB;
    localparam logic [7:0] OP_IDLE_CYCLE = 8'h2D;
    localparam logic [7:0] OP_SUB_EXIT = 8'hCD;
    localparam logic [7:0] OP_INT_EXIT = 8'h4D;
    localparam logic [7:0] OP_HALT_CLOCK = 8'h6D;
    localparam logic [7:0] OP_IDLE_UNTIL_INT = 8'hED;

    // ------------------------------------------------------------------
    // Program counter steps
    // ------------------------------------------------------------------
    localparam logic [PC_W-1:0] LEN_ONE = 12'h001;
    localparam logic [PC_W-1:0] LEN_TWO = 12'h002;
    localparam logic [PC_W-1:0] LEN_THREE = 12'h003;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum {ST_FETCH, ST_DECODE, ST_ARG, ST_MEM, ST_PAD, ST_SLEEP} bbx_state_t;
    typedef enum {K_ILLEGAL, K_REL, K_BTEST, K_BMOD, K_JUMP, K_CALL, K_IDLE_CYCLE,
                  K_SUB_EXIT, K_INT_EXIT, K_HALT_CLOCK, K_IDLE_UNTIL_INT} bbx_kind_t;

    typedef struct packed {
        logic zero;
        logic carry;
    } bbx_flags_t;

    typedef struct packed {
        logic [DS_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic rd;
        logic wr;
    } bbx_ds_req_t;

endpackage
`default_nettype wire

// [logic/bbx_exec.sv]
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Carry/no-carry/zero/nonzero one-byte branches take 2 cycles, flags untouched.
// - Short branch displacement is 5-bit signed, reaching -15 to +16 from instruction.
// - Bit-test branches: three bytes, 5 cycles, reach -126 to +129 from instruction.
// - Bit-test branch copies tested bit into carry always; zero stays.
// - Bit set/clear on any data byte, two bytes, 4 cycles, flags untouched.
// - Control instructions are one byte; all but halt and idle-until-interrupt take 2 cycles; only interrupt exit changes flags.
// - With watchdog selected, halt is replaced by idle-until-interrupt.
// - Long jump and call are two bytes, 4 cycles, 12-bit target, flags untouched.
// - Short branch opcode holds a condition field and a 5-bit two's-complement displacement field.
// - Bit number comes from opcode, byte address from the following byte.
module bbx_exec (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    output logic [bbx_pkg::PC_W-1:0] o_pm_addr,
    input wire logic [bbx_pkg::DATA_W-1:0] i_pm_data,
    output bbx_pkg::bbx_ds_req_t o_ds,
    input wire logic [bbx_pkg::DATA_W-1:0] i_ds_rdata,
    output bbx_pkg::bbx_flags_t o_flags,
    input wire bbx_pkg::bbx_flags_t i_interrupt_exit_instr_flags,
    input wire logic i_wdg_sel,
    input wire logic i_wake,
    output logic o_halted,
    output logic o_idling
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic bbx_pkg::bbx_kind_t classify(input logic [7:0] op);
        bbx_pkg::bbx_kind_t k;
        k = bbx_pkg::K_ILLEGAL;
        if (op[0] == 1'b0 && (op[2:0] == bbx_pkg::COND_NZ || op[2:0] == bbx_pkg::COND_NC ||
            op[2:0] == bbx_pkg::COND_Z || op[2:0] == bbx_pkg::COND_C)) begin
            k = bbx_pkg::K_REL;
        end else if (op[3:0] == bbx_pkg::COL_BTEST) begin
            k = bbx_pkg::K_BTEST;
        end else if (op[3:0] == bbx_pkg::COL_BMOD) begin
            k = bbx_pkg::K_BMOD;
        end else if (op[3:0] == bbx_pkg::COL_JUMP) begin
            k = bbx_pkg::K_JUMP;
        end else if (op[3:0] == bbx_pkg::COL_CALL) begin
            k = bbx_pkg::K_CALL;
        end else if (op == bbx_pkg::OP_IDLE_CYCLE) begin
            k = bbx_pkg::K_IDLE_CYCLE;
        end else if (op == bbx_pkg::OP_SUB_EXIT) begin
            k = bbx_pkg::K_SUB_EXIT;
        end else if (op == bbx_pkg::OP_INT_EXIT) begin
            k = bbx_pkg::K_INT_EXIT;
        end else if (op == bbx_pkg::OP_HALT_CLOCK) begin
            k = bbx_pkg::K_HALT_CLOCK;
        end else if (op == bbx_pkg::OP_IDLE_UNTIL_INT) begin
            k = bbx_pkg::K_IDLE_UNTIL_INT;
        end
        return k;
    endfunction

    // Bit numbers are laid out bit-reversed across the opcode rows.
    function automatic logic [2:0] bit_index(input logic [7:0] op);
        return {op[5], op[6], op[7]};
    endfunction

    // Addition wraps naturally inside the program space.
    function automatic logic [bbx_pkg::PC_W-1:0] rel_target(
        input logic [bbx_pkg::PC_W-1:0] base,
        input logic [bbx_pkg::PC_W-1:0] len,
        input logic [bbx_pkg::PC_W-1:0] disp
    );
        return base + len + disp;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    bbx_pkg::bbx_state_t state_r;
    bbx_pkg::bbx_state_t state_nxt;
    bbx_pkg::bbx_kind_t kind_r;
    bbx_pkg::bbx_kind_t kind_now;
    logic [bbx_pkg::PC_W-1:0] pc_r;
    logic [bbx_pkg::PC_W-1:0] pc_nxt;
    logic [bbx_pkg::PC_W-1:0] pm_addr_r;
    logic [bbx_pkg::PC_W-1:0] pm_addr_nxt;
    logic [bbx_pkg::PC_W-1:0] target_r;
    logic [bbx_pkg::PC_W-1:0] target_nxt;
    logic [7:0] op_r;
    logic [bbx_pkg::PC_W-1:0] stack_r [bbx_pkg::STACK_DEPTH];
    logic [bbx_pkg::SP_W-1:0] sp_r;
    logic [bbx_pkg::PC_W-1:0] stack_top;
    bbx_pkg::bbx_flags_t flags_r;
    bbx_pkg::bbx_ds_req_t ds_r;
    logic halted_r;
    logic idling_r;
    logic rel_take;
    logic tested_bit;
    logic [bbx_pkg::PC_W-1:0] short_disp;
    logic [bbx_pkg::PC_W-1:0] long_disp;
    logic [2:0] cond;

    assign kind_now = classify(i_pm_data);
    assign cond = i_pm_data[bbx_pkg::COND_LSB +: 3];
    assign short_disp = {{7{i_pm_data[7]}}, i_pm_data[bbx_pkg::REL_DISP_LSB +: 5]};
    assign long_disp = {{4{i_pm_data[7]}}, i_pm_data};
    assign tested_bit = i_ds_rdata[bit_index(op_r)];
    assign stack_top = (sp_r == '0) ? stack_r[0] : stack_r[sp_r - 3'h1];

    always_comb begin
        unique case (cond)
            bbx_pkg::COND_NZ: rel_take = ~flags_r.zero;
            bbx_pkg::COND_Z: rel_take = flags_r.zero;
            bbx_pkg::COND_NC: rel_take = ~flags_r.carry;
            default: rel_take = flags_r.carry;
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        pm_addr_nxt = pm_addr_r;
        target_nxt = target_r;
        unique case (state_r)
            bbx_pkg::ST_FETCH: begin
                // Prefetch the operand byte so two-byte forms need no stall.
                pm_addr_nxt = pc_r + bbx_pkg::LEN_ONE;
                state_nxt = bbx_pkg::ST_DECODE;
            end
            bbx_pkg::ST_DECODE: begin
                unique case (kind_now)
                    bbx_pkg::K_REL: begin
                        pc_nxt = rel_take ? rel_target(pc_r, bbx_pkg::LEN_ONE, short_disp)
                                          : pc_r + bbx_pkg::LEN_ONE;
                        state_nxt = bbx_pkg::ST_FETCH;
                    end
                    bbx_pkg::K_SUB_EXIT, bbx_pkg::K_INT_EXIT: begin
                        pc_nxt = stack_top;
                        state_nxt = bbx_pkg::ST_FETCH;
                    end
                    bbx_pkg::K_HALT_CLOCK, bbx_pkg::K_IDLE_UNTIL_INT: begin
                        pc_nxt = pc_r + bbx_pkg::LEN_ONE;
                        state_nxt = bbx_pkg::ST_SLEEP;
                    end
                    bbx_pkg::K_BTEST, bbx_pkg::K_BMOD, bbx_pkg::K_JUMP, bbx_pkg::K_CALL: begin
                        pm_addr_nxt = pc_r + bbx_pkg::LEN_TWO;
                        state_nxt = bbx_pkg::ST_ARG;
                    end
                    default: begin
                        pc_nxt = pc_r + bbx_pkg::LEN_ONE;
                        state_nxt = bbx_pkg::ST_FETCH;
                    end
                endcase
            end
            bbx_pkg::ST_ARG: begin
                if (kind_r == bbx_pkg::K_JUMP || kind_r == bbx_pkg::K_CALL) begin
                    target_nxt = {op_r[bbx_pkg::ADDR_HI_LSB +: 4], i_pm_data};
                    state_nxt = bbx_pkg::ST_PAD;
                end else begin
                    state_nxt = bbx_pkg::ST_MEM;
                end
            end
            bbx_pkg::ST_MEM: begin
                if (kind_r == bbx_pkg::K_BTEST) begin
                    target_nxt = (tested_bit == op_r[bbx_pkg::BIT_POLARITY_POS])
                               ? rel_target(pc_r, bbx_pkg::LEN_TWO, long_disp)
                               : pc_r + bbx_pkg::LEN_THREE;
                    state_nxt = bbx_pkg::ST_PAD;
                end else begin
                    pc_nxt = pc_r + bbx_pkg::LEN_TWO;
                    state_nxt = bbx_pkg::ST_FETCH;
                end
            end
            bbx_pkg::ST_PAD: begin
                pc_nxt = target_r;
                state_nxt = bbx_pkg::ST_FETCH;
            end
            bbx_pkg::ST_SLEEP: begin
                if (i_wake) begin
                    state_nxt = bbx_pkg::ST_FETCH;
                end
            end
        endcase
        if (state_nxt == bbx_pkg::ST_FETCH) begin
            pm_addr_nxt = pc_nxt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_r <= bbx_pkg::ST_FETCH;
            pc_r <= bbx_pkg::RESET_PC;
            pm_addr_r <= bbx_pkg::RESET_PC;
            target_r <= bbx_pkg::RESET_PC;
            op_r <= 8'h00;
            kind_r <= bbx_pkg::K_ILLEGAL;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            pm_addr_r <= pm_addr_nxt;
            target_r <= target_nxt;
            if (state_r == bbx_pkg::ST_DECODE) begin
                op_r <= i_pm_data;
                kind_r <= kind_now;
            end
        end
    end

    // ------------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------------
    // A full stack keeps overwriting its top entry rather than wrapping around.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sp_r <= '0;
            for (int i = 0; i < bbx_pkg::STACK_DEPTH; i++) begin
                stack_r[i] <= bbx_pkg::RESET_PC;
            end
        end else if (state_r == bbx_pkg::ST_ARG && kind_r == bbx_pkg::K_CALL) begin
            stack_r[(sp_r > bbx_pkg::STACK_LAST) ? bbx_pkg::STACK_LAST : sp_r] <= pc_r + bbx_pkg::LEN_TWO;
            if (sp_r <= bbx_pkg::STACK_LAST) begin
                sp_r <= sp_r + 3'h1;
            end
        end else if (state_r == bbx_pkg::ST_DECODE &&
                     (kind_now == bbx_pkg::K_SUB_EXIT || kind_now == bbx_pkg::K_INT_EXIT)) begin
            if (sp_r != '0) begin
                sp_r <= sp_r - 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            flags_r <= '0;
        end else if (state_r == bbx_pkg::ST_DECODE && kind_now == bbx_pkg::K_INT_EXIT) begin
            flags_r <= i_interrupt_exit_instr_flags;
        end else if (state_r == bbx_pkg::ST_MEM && kind_r == bbx_pkg::K_BTEST) begin
            flags_r.carry <= tested_bit;
        end
    end

    // ------------------------------------------------------------------
    // Data space access
    // ------------------------------------------------------------------
    // Bit modify is a full read-modify-write of the byte, so other bits of
    // registers with side effects on access may be disturbed.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ds_r <= '0;
        end else begin
            ds_r.wr <= 1'b0;
            ds_r.rd <= 1'b0;
            if (state_r == bbx_pkg::ST_ARG &&
                (kind_r == bbx_pkg::K_BTEST || kind_r == bbx_pkg::K_BMOD)) begin
                ds_r.addr <= i_pm_data;
                ds_r.rd <= 1'b1;
            end
            if (state_r == bbx_pkg::ST_MEM && kind_r == bbx_pkg::K_BMOD) begin
                ds_r.wdata <= i_ds_rdata;
                ds_r.wdata[bit_index(op_r)] <= op_r[bbx_pkg::BIT_POLARITY_POS];
                ds_r.wr <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            halted_r <= 1'b0;
            idling_r <= 1'b0;
        end else if (state_r == bbx_pkg::ST_DECODE && kind_now == bbx_pkg::K_HALT_CLOCK) begin
            halted_r <= ~i_wdg_sel;
            idling_r <= i_wdg_sel;
        end else if (state_r == bbx_pkg::ST_DECODE && kind_now == bbx_pkg::K_IDLE_UNTIL_INT) begin
            idling_r <= 1'b1;
        end else if (state_r == bbx_pkg::ST_SLEEP && i_wake) begin
            halted_r <= 1'b0;
            idling_r <= 1'b0;
        end
    end

    assign o_pm_addr = pm_addr_r;
    assign o_ds = ds_r;
    assign o_flags = flags_r;
    assign o_halted = halted_r;
    assign o_idling = idling_r;

endmodule
`default_nettype wire

// [testbench/bbx_exec_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module bbx_exec_assertions (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire bbx_pkg::bbx_ds_req_t o_ds,
    input wire logic [bbx_pkg::DATA_W-1:0] i_ds_rdata,
    input wire bbx_pkg::bbx_flags_t o_flags,
    input wire logic i_wdg_sel,
    input wire logic i_wake,
    input wire logic o_halted,
    input wire logic o_idling
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    property p_wr_after_rd; o_ds.wr |-> $past(o_ds.rd) && o_ds.addr == $past(o_ds.addr); endproperty
    a_wr_after_rd: assert property (p_wr_after_rd) else $error("write not preceded by read of same byte");
    property p_one_bit; o_ds.wr |-> $countones(o_ds.wdata ^ $past(i_ds_rdata)) <= 1; endproperty
    a_one_bit: assert property (p_one_bit) else $error("write changed more than one bit");
    property p_wr_flags; o_ds.wr |-> $stable(o_flags); endproperty
    a_wr_flags: assert property (p_wr_flags) else $error("flags moved during bit write");
    property p_rd_once; o_ds.rd |=> !o_ds.rd [*3]; endproperty
    a_rd_once: assert property (p_rd_once) else $error("data read repeated too soon");
    property p_wr_once; o_ds.wr |=> !o_ds.wr [*3]; endproperty
    a_wr_once: assert property (p_wr_once) else $error("data write repeated too soon");
    property p_halt_wdg; $rose(o_halted) |-> !$past(i_wdg_sel); endproperty
    a_halt_wdg: assert property (p_halt_wdg) else $error("halt taken with watchdog selected");
    property p_excl; o_halted |-> !o_idling; endproperty
    a_excl: assert property (p_excl) else $error("halt and idle both set");
    property p_wake; (o_halted || o_idling) && i_wake |=> !o_halted && !o_idling; endproperty
    a_wake: assert property (p_wake) else $error("sleep not left on wake");
    property p_stay; o_halted && !i_wake |=> o_halted; endproperty
    a_stay: assert property (p_stay) else $error("halt left without wake");
    property p_sleep_flags; $past(o_halted || o_idling) && (o_halted || o_idling) |-> $stable(o_flags); endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("flags moved while asleep");
    c_wr: cover property (o_ds.wr);
    c_halt: cover property ($rose(o_halted));
    c_idle: cover property ($rose(o_idling));
endmodule
bind bbx_exec bbx_exec_assertions u_chk (
    .i_clk,
    .i_sys_rst,
    .o_ds,
    .i_ds_rdata,
    .o_flags,
    .i_wdg_sel,
    .i_wake,
    .o_halted,
    .o_idling
);
`default_nettype wire

// [testbench/bbx_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module bbx_mem_model (
    input wire logic i_clk,
    input wire logic [bbx_pkg::PC_W-1:0] i_pm_addr,
    output logic [bbx_pkg::DATA_W-1:0] o_pm_data,
    input wire bbx_pkg::bbx_ds_req_t i_ds,
    output logic [bbx_pkg::DATA_W-1:0] o_ds_rdata
);
    // ------------------------------------------------------------------
    // Program and data storage
    // ------------------------------------------------------------------
    logic [7:0] pm [4096];
    logic [7:0] ds [256];
    initial begin
        foreach (pm[i]) begin
            pm[i] = 8'h2D;
        end
    end
    always @(posedge i_clk) begin
        o_pm_data <= pm[i_pm_addr];
    end
    // Outside a read cycle the bus shows the inverse, so a stale sample cannot pass.
    assign o_ds_rdata = i_ds.rd ? ds[i_ds.addr] : ~ds[i_ds.addr];
    always @(posedge i_clk) begin
        if (i_ds.wr) begin
            ds[i_ds.addr] <= i_ds.wdata;
        end
    end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic i_clk;
    logic i_sys_rst;
    logic [bbx_pkg::PC_W-1:0] o_pm_addr;
    logic [bbx_pkg::DATA_W-1:0] i_pm_data;
    bbx_pkg::bbx_ds_req_t o_ds;
    logic [bbx_pkg::DATA_W-1:0] i_ds_rdata;
    bbx_pkg::bbx_flags_t o_flags;
    bbx_pkg::bbx_flags_t i_interrupt_exit_instr_flags;
    logic i_wdg_sel;
    logic i_wake;
    logic o_halted;
    logic o_idling;
    int failures;
    int checks_done;
    bbx_exec DUT (
        .i_clk,
        .i_sys_rst,
        .o_pm_addr,
        .i_pm_data,
        .o_ds,
        .i_ds_rdata,
        .o_flags,
        .i_interrupt_exit_instr_flags,
        .i_wdg_sel,
        .i_wake,
        .o_halted,
        .o_idling
    );
    bbx_mem_model u_mem (
        .i_clk,
        .i_pm_addr(o_pm_addr),
        .o_pm_data(i_pm_data),
        .i_ds(o_ds),
        .o_ds_rdata(i_ds_rdata)
    );
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // A call to 010h, where an interrupt exit loads the flags and returns to 002h.
    task automatic boot(input bbx_pkg::bbx_flags_t f);
        i_interrupt_exit_instr_flags = f;
        u_mem.pm[0] = 8'h01;
        u_mem.pm[1] = 8'h10;
        u_mem.pm[16] = 8'h4D;
        i_sys_rst = 1'b1;
        repeat (3) @(negedge i_clk);
        i_sys_rst = 1'b0;
        repeat (6) @(negedge i_clk);
        check(16'(o_pm_addr), 16'h0002);
        check(16'(o_flags), 16'(f));
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_branch();
        logic [2:0] cond;
        logic v;
        logic [4:0] e;
        bbx_pkg::bbx_flags_t f;
        logic [11:0] exp;
        for (int k = 0; k < 8; k++) begin
            cond = {k[2:1], 1'b0};
            v = k[0];
            f = cond[1] ? {~v, v} : {v, ~v};
            e = v ? 5'h10 : 5'h0F;
            u_mem.pm[2] = {e, cond};
            boot(f);
            repeat (2) @(negedge i_clk);
            exp = (v == cond[2]) ? 12'h003 + {{7{e[4]}}, e} : 12'h003;
            check(16'(o_pm_addr), 16'(exp));
            check(16'(o_flags), 16'(f));
        end
        $display("short branch test done");
    endtask
    // Bit operations aim only at plain RAM bytes, never at port registers.
    task automatic t_btest();
        logic [2:0] b;
        logic p;
        logic [7:0] ee;
        logic [7:0] pat;
        logic [11:0] exp;
        pat = 8'hA5;
        u_mem.ds[8'h40] = pat;
        for (int k = 0; k < 16; k++) begin
            b = k[2:0];
            p = k[3];
            ee = p ? 8'h80 : 8'h7F;
            u_mem.pm[2] = {b[0], b[1], b[2], p, 4'h3};
            u_mem.pm[3] = 8'h40;
            u_mem.pm[4] = ee;
            boot({1'b1, ~pat[b]});
            repeat (5) @(negedge i_clk);
            exp = (pat[b] == p) ? 12'h004 + {{4{ee[7]}}, ee} : 12'h005;
            check(16'(o_pm_addr), 16'(exp));
            check(16'(o_flags), {14'h0000, 1'b1, pat[b]});
        end
        check(16'(u_mem.ds[8'h40]), 16'(pat));
        $display("bit test branch test done");
    endtask
    task automatic t_bmod();
        logic [2:0] b;
        logic [7:0] m;
        for (int k = 0; k < 16; k++) begin
            b = k[2:0];
            m = 8'h5A;
            u_mem.ds[8'h41] = m;
            m[b] = k[3];
            u_mem.pm[2] = {b[0], b[1], b[2], k[3], 4'hB};
            u_mem.pm[3] = 8'h41;
            boot(2'(k));
            repeat (4) @(negedge i_clk);
            check(16'(o_pm_addr), 16'h0004);
            check({o_ds.wr, o_ds.addr, 7'h00}, {1'b1, 8'h41, 7'h00});
            check(16'(o_ds.wdata), 16'(m));
            check(16'(o_flags), 16'(k[1:0]));
            @(negedge i_clk);
            check(16'(u_mem.ds[8'h41]), 16'(m));
        end
        $display("bit modify test done");
    endtask
    task automatic t_ctrl();
        u_mem.pm[2] = 8'h01;
        u_mem.pm[3] = 8'h20;
        u_mem.pm[32] = 8'hCD;
        boot(2'h3);
        repeat (4) @(negedge i_clk);
        check(16'(o_pm_addr), 16'h0020);
        repeat (2) @(negedge i_clk);
        check(16'(o_pm_addr), 16'h0004);
        check(16'(o_flags), 16'h0003);
        u_mem.pm[2] = 8'hA9;
        u_mem.pm[3] = 8'h5C;
        boot(2'h1);
        repeat (4) @(negedge i_clk);
        check(16'(o_pm_addr), 16'h0A5C);
        check(16'(o_flags), 16'h0001);
        for (int k = 0; k < 2; k++) begin
            u_mem.pm[2] = k[0] ? 8'h05 : 8'h2D;
            boot(2'h2);
            repeat (2) @(negedge i_clk);
            check(16'(o_pm_addr), 16'h0003);
            check(16'(o_flags), 16'h0002);
        end
        $display("jump and control test done");
    endtask
    task automatic t_sleep();
        logic he;
        for (int k = 0; k < 3; k++) begin
            he = (k == 0);
            u_mem.pm[2] = (k == 2) ? 8'hED : 8'h6D;
            i_wdg_sel = k[0];
            boot(2'h1);
            repeat (6) @(negedge i_clk);
            check({o_halted, o_idling}, {14'h0000, he, ~he});
            check(16'(o_flags), 16'h0001);
            i_wake = 1'b1;
            @(negedge i_clk);
            i_wake = 1'b0;
            check({o_halted, o_idling, o_pm_addr}, 16'h0003);
        end
        i_wdg_sel = 1'b0;
        $display("sleep test done");
    endtask
    initial begin
        repeat (8000) @(posedge i_clk);
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end
    initial begin
        failures = 0;
        checks_done = 0;
        i_sys_rst = 1'b1;
        i_interrupt_exit_instr_flags = 2'h0;
        i_wdg_sel = 1'b0;
        i_wake = 1'b0;
        t_branch();
        t_btest();
        t_bmod();
        t_ctrl();
        t_sleep();
        end_of_test();
    end
endmodule
`default_nettype wire
